/* File: design/power_state_ctrl.sv */
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pwr_consts.svh"
// Behaviour
// (RULE_01) From soft-off, a press under four seconds powers the system on.
// (RULE_02) From working, a press under four seconds puts the system to sleep.
// (RULE_03) A hold of four seconds or more, working or sleeping, forces soft-off.
// (RULE_04) From sleep, a press under four seconds wakes to working.
// (RULE_05) Software commands transitions; hardware only reacts to switch and wakes.
// (RULE_06) A software soft-off request drops main power and enters soft-off.
// (RULE_07) S4 keeps context on disk; leaving S5 runs a full cold boot.
// (RULE_08) Wake logic stays powered in S4 and S5, unpowered only mechanically off.
// (RULE_09) Network and PME wake from S1, S4, S5; S5 only when enabled.
// (RULE_10) Modem ring wakes only from S1.
// (RULE_11) Switch and RTC alarm wake from S1, S4 and S5.
// (RULE_12) Keyboard, mouse and USB wake only from S1.
// (RULE_13) Green LED off without link, on with link, blinking with traffic.
// (RULE_14) Yellow LED off at 10 Mbit/s, on at 100 Mbit/s.
// (RULE_15) Fans on in S0 and S1, off in S4, S5 and off.
// (RULE_16) Hold time counted after debounce; exactly the threshold counts long.
// (RULE_17) Wakes ignored while working; a wake latches until power-up begins.
module power_state_ctrl
#(
   parameter int HOLD_CYC = `HOLD_CYC,
   parameter int BLINK_CYC = `BLINK_CYC
)
(
   // Clock and reset, always-on standby domain
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Front panel switch and wake sources, asynchronous pins
   input wire logic pwr_sw_i,
   input wire pwr_pkg::wake_t wake_i,
   // Network port status, asynchronous pins
   input wire logic link_up_i,
   input wire logic link_act_i,
   input wire logic link_100_i,
   // Power rails, fans, indicators
   output logic main_pwr_o,
   output logic cpu_pwr_o,
   output logic fan_en_o,
   output logic cold_boot_o,
   output logic led_green_o,
   output logic led_yellow_o,
   output logic irq_o
);

   // Two-stage synchronisers for every asynchronous pin (switch, wake and network status)
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   wire [NSYNC-1:0] pins = {pwr_sw_i, wake_i, link_up_i, link_act_i,
                            link_100_i};
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync_a <= '0;
         sync_b <= '0;
      end
      else
      begin
         sync_a <= pins;
         sync_b <= sync_a;
      end
   end

   wire sw_s = sync_b[9];
   pwr_pkg::wake_t wk;
   assign wk = sync_b[8:3];
   wire up_s = sync_b[2];
   wire act_s = sync_b[1];
   wire fast_s = sync_b[0];

   logic press_short;
   logic press_long;
   switch_timer #(.HOLD_CYC(HOLD_CYC)) u_sw
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sw_i(sw_s),
      .short_o(press_short),
      .long_o(press_long)
   );

   // Registers
   pwr_pkg::pstate_t state;
   pwr_pkg::pstate_t next_state;
   logic [1:0] cfg;
   logic [`IRQ_W-1:0] irq_stat;
   logic [`IRQ_W-1:0] irq_mask;
   logic wake_pend;
   logic from_s5;
   logic [4:0] boot_cnt;

   // Bus decode
   // Ack low is part of a take, so a held strobe is not taken twice
   wire req = cyc_i && stb_i && !ack_o;
   wire wr = req && we_i && sel_i[0];
   wire hit_state = adr_i == `OFF_STATE;
   wire hit_cmd = adr_i == `OFF_CMD;
   wire hit_cfg = adr_i == `OFF_CFG;
   wire hit_stat = adr_i == `OFF_IRQ_STAT;
   wire hit_mask = adr_i == `OFF_IRQ_MASK;
   wire hit_link = adr_i == `OFF_LINK;
   wire [2:0] cmd = (wr && hit_cmd) ? dat_i[2:0] : `CMD_NONE;

   function automatic logic is_sleep(input pwr_pkg::pstate_t s);
      is_sleep = (s == pwr_pkg::ST_S1) || (s == pwr_pkg::ST_S4) ||
                 (s == pwr_pkg::ST_S5);
   endfunction

   // Wake qualification by state
   wire in_s1 = state == pwr_pkg::ST_S1;
   wire in_s4 = state == pwr_pkg::ST_S4;
   wire in_s5 = state == pwr_pkg::ST_S5;
   // Boot runs on main power but is not asleep, so wakes are not latched
   wire in_boot = state == pwr_pkg::ST_BOOT;
   wire deep = in_s4 || in_s5;
   wire lan_ok = wk.lan && (in_s1 || in_s4 ||
                 (in_s5 && cfg[`CFG_S5_LAN_EN])); // see (RULE_09)
   wire pme_ok = wk.pme && (in_s1 || in_s4 ||
                 (in_s5 && cfg[`CFG_S5_PME_EN])); // see (RULE_09)
   wire ring_ok = wk.ring && in_s1; // see (RULE_10)
   wire rtc_ok = wk.rtc && (in_s1 || deep); // see (RULE_11)
   wire hid_ok = (wk.kbd || wk.usb) && in_s1; // see (RULE_12)
   // Sleeping states keep wake logic alive, so LAN, PME and RTC are live in S4 and S5 (LAN and PME in S5 only when enabled)
   wire wake_hit = lan_ok || pme_ok || ring_ok || rtc_ok || hid_ok; // see (RULE_08)
   wire sw_wake = press_short && is_sleep(state); // see (RULE_11)

   // State transitions; long press has top priority
   always_comb
   begin
      next_state = state;
      case (state)
         pwr_pkg::ST_S0:
         begin
            if (press_long)
               next_state = pwr_pkg::ST_S5; // see (RULE_03)
            else if (press_short)
               next_state = pwr_pkg::ST_S1; // see (RULE_02)
            else if (cmd == `CMD_SOFT_OFF)
               next_state = pwr_pkg::ST_S5; // see (RULE_06)
            else if (cmd == `CMD_SLEEP_S1)
               next_state = pwr_pkg::ST_S1; // see (RULE_05)
            else if (cmd == `CMD_SLEEP_S4)
               next_state = pwr_pkg::ST_S4; // see (RULE_05)
         end
         pwr_pkg::ST_S1, pwr_pkg::ST_S4:
         begin
            if (press_long)
               next_state = pwr_pkg::ST_S5; // see (RULE_03)
            else if (wake_pend)
               next_state = in_s4 ? pwr_pkg::ST_BOOT : pwr_pkg::ST_S0; // see (RULE_04)
            else if (cmd == `CMD_SOFT_OFF)
               next_state = pwr_pkg::ST_S5; // see (RULE_06)
         end
         pwr_pkg::ST_S5:
         begin
            if (wake_pend)
               next_state = pwr_pkg::ST_BOOT; // see (RULE_01)
         end
         pwr_pkg::ST_BOOT:
         begin
            if (press_long)
               next_state = pwr_pkg::ST_S5;
            else if (boot_cnt == 5'(`BOOT_CYC - 1))
               next_state = pwr_pkg::ST_S0;
         end
         default: next_state = pwr_pkg::ST_S5;
      endcase
   end

   // Power-up begins when a sleeping state leaves for boot or working
   wire power_up = (next_state == pwr_pkg::ST_BOOT ||
                    next_state == pwr_pkg::ST_S0) && is_sleep(state);
   // A fail-safe off must not be undone by a wake that was still pending
   wire to_off = next_state == pwr_pkg::ST_S5 && state != pwr_pkg::ST_S5;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= pwr_pkg::ST_S5;
         wake_pend <= 1'b0;
         from_s5 <= 1'b0;
         boot_cnt <= 5'h00;
      end
      else
      begin
         state <= next_state;
         // Latched until power-up starts or an entry to soft-off; never set while working
         if (power_up || to_off)
            wake_pend <= 1'b0; // see (RULE_17)
         else if (is_sleep(state) && (wake_hit || sw_wake))
            wake_pend <= 1'b1; // see (RULE_17)
         if (state == pwr_pkg::ST_S5 && next_state == pwr_pkg::ST_BOOT)
            from_s5 <= 1'b1; // see (RULE_07)
         else if (next_state == pwr_pkg::ST_S0)
            from_s5 <= 1'b0;
         boot_cnt <= in_boot ? boot_cnt + 5'h01 : 5'h00;
      end
   end

   // Rails: CPU unpowered in S4 and S5, main rail off outside S0, S1, boot
   wire run = state == pwr_pkg::ST_S0 || state == pwr_pkg::ST_S1;
   wire powered = run || in_boot;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         main_pwr_o <= 1'b0;
         cpu_pwr_o <= 1'b0;
         fan_en_o <= 1'b0;
         cold_boot_o <= 1'b0;
      end
      else
      begin
         main_pwr_o <= powered; // see (RULE_06)
         cpu_pwr_o <= powered; // see (RULE_07)
         fan_en_o <= run; // see (RULE_15)
         cold_boot_o <= in_boot && from_s5; // see (RULE_07)
      end
   end

   // Indicators; blink rate trades visibility against a wide counter
   logic [31:0] blink_cnt;
   logic blink;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         blink_cnt <= 32'h0000_0000;
         blink <= 1'b0;
         led_green_o <= 1'b0;
         led_yellow_o <= 1'b0;
      end
      else
      begin
         if (blink_cnt == 32'(BLINK_CYC - 1))
         begin
            blink_cnt <= 32'h0000_0000;
            blink <= !blink;
         end
         else
            blink_cnt <= blink_cnt + 32'h0000_0001;
         led_green_o <= up_s && (!act_s || blink); // see (RULE_13)
         led_yellow_o <= fast_s; // see (RULE_14)
      end
   end

   // Interrupts: set wins over write-one-to-clear
   wire [`IRQ_W-1:0] ev;
   assign ev[`IRQ_WAKE] = power_up;
   assign ev[`IRQ_SHORT] = press_short;
   assign ev[`IRQ_LONG] = press_long;
   assign ev[`IRQ_STATE] = next_state != state;
   // Write one to clear; an event in the same cycle keeps its bit
   wire [`IRQ_W-1:0] clr = (wr && hit_stat) ? dat_i[`IRQ_W-1:0] : '0;
   assign irq_o = |(irq_stat & irq_mask);

   wire [31:0] rd_data = hit_state ? {29'h0, state} :
                         hit_cfg ? {30'h0, cfg} :
                         hit_stat ? {28'h0, irq_stat} :
                         hit_mask ? {28'h0, irq_mask} :
                         hit_link ?
                            {29'h0, fast_s, act_s, up_s} : 32'h0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg <= `CFG_RESET;
         irq_stat <= '0;
         irq_mask <= '0;
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end
      else
      begin
         irq_stat <= (irq_stat & ~clr) | ev;
         if (wr && hit_cfg)
            cfg <= dat_i[1:0];
         if (wr && hit_mask)
            irq_mask <= dat_i[`IRQ_W-1:0];
         // Registered ack costs one wait state but keeps bus timing flat
         ack_o <= req;
         if (req && !we_i)
            dat_o <= rd_data;
      end
   end
endmodule
`default_nettype wire

/* File: pkg/pwr_consts.svh */
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH
// Register byte offsets
`define OFF_STATE     8'h00
`define OFF_CMD       8'h04
`define OFF_CFG       8'h08
`define OFF_IRQ_STAT  8'h0c
`define OFF_IRQ_MASK  8'h10
`define OFF_LINK      8'h14
// Command codes (written to OFF_CMD)
`define CMD_NONE      3'h0
`define CMD_SLEEP_S1  3'h1
`define CMD_SLEEP_S4  3'h2
`define CMD_SOFT_OFF  3'h3
// Config fields
`define CFG_S5_LAN_EN 0
`define CFG_S5_PME_EN 1
`define CFG_RESET     2'h0
// Status / mask bit positions
`define IRQ_WAKE      0
`define IRQ_SHORT     1
`define IRQ_LONG      2
`define IRQ_STATE     3
`define IRQ_W         4
// Timing
`define CLK_HZ        125000000
`define HOLD_MS       4000
`define HOLD_CYC      ((`CLK_HZ / 1000) * `HOLD_MS)
`define DEB_US        10
`define DEB_CYC       ((`CLK_HZ / 1000000) * `DEB_US)
`define BLINK_MS      50
`define BLINK_CYC     ((`CLK_HZ / 1000) * `BLINK_MS)
`define BOOT_CYC      16
`endif

/* File: pkg/pwr_pkg.sv */
package pwr_pkg;
   typedef enum logic [2:0]
   {
      ST_S0 = 3'b000,
      ST_S1 = 3'b001,
      ST_S4 = 3'b010,
      ST_S5 = 3'b011,
      ST_BOOT = 3'b100
   } pstate_t;
   typedef struct packed
   {
      logic lan;
      logic pme;
      logic ring;
      logic kbd;
      logic usb;
      logic rtc;
   } wake_t;
endpackage

/* File: design/switch_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pwr_consts.svh"
// Debounces the switch and classifies each press by its hold time
module switch_timer
#(
   parameter int HOLD_CYC = `HOLD_CYC
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Synchronised switch level
   input wire logic sw_i,
   // Press classification pulses
   output logic short_o,
   output logic long_o
);
   logic deb;
   logic [15:0] deb_cnt;
   logic [31:0] hold;
   logic long_done;
   wire deb_flip = (sw_i != deb) && (deb_cnt == 16'(`DEB_CYC - 1));
   wire at_long = deb && (hold == 32'(HOLD_CYC - 1)) && !long_done;
   wire release_now = deb_flip && deb;
   // Long fires when the threshold is reached, so exactly four seconds is long
   assign long_o = at_long; // see (RULE_16)
   assign short_o = release_now && !long_done && (hold < 32'(HOLD_CYC)); // see (RULE_16)
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         deb <= 1'b0;
         deb_cnt <= 16'h0000;
      end
      else if (sw_i == deb)
         deb_cnt <= 16'h0000;
      else if (deb_flip)
      begin
         deb <= sw_i; // see (RULE_16)
         deb_cnt <= 16'h0000;
      end
      else
         deb_cnt <= deb_cnt + 16'h0001;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hold <= 32'h0000_0000;
         long_done <= 1'b0;
      end
      else if (!deb)
      begin
         hold <= 32'h0000_0000;
         long_done <= 1'b0;
      end
      else
      begin
         if (hold != 32'hffff_ffff)
            hold <= hold + 32'h0000_0001; // see (RULE_16)
         if (at_long)
            long_done <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: test/pwr_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module pwr_checker
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus handshake
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   // Network status pins
   input wire logic link_up_i,
   input wire logic link_act_i,
   input wire logic link_100_i,
   // Rails and indicators
   input wire logic main_pwr_o,
   input wire logic cpu_pwr_o,
   input wire logic fan_en_o,
   input wire logic cold_boot_o,
   input wire logic led_green_o,
   input wire logic led_yellow_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_ack_one: assert property (ack_o |=> !ack_o)
      else $error("ack held beyond one cycle");
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not answered next cycle");
   a_fan_power: assert property (fan_en_o |-> main_pwr_o)
      else $error("fan enabled without main power");
   a_cpu_rail: assert property (cpu_pwr_o == main_pwr_o)
      else $error("processor rail differs from main rail");
   a_boot_rails: assert property
      (cold_boot_o |-> main_pwr_o && !fan_en_o)
      else $error("cold boot outside powered boot");
   a_yellow_rate: assert property
      (link_100_i [*5] |-> led_yellow_o)
      else $error("yellow off at fast rate");
   a_green_off: assert property
      (!link_up_i [*5] |-> !led_green_o)
      else $error("green lit without link");
   a_green_on: assert property
      ((link_up_i && !link_act_i) [*5] |-> led_green_o)
      else $error("green dark with idle link");
   c_boot: cover property ($rose(cold_boot_o));
   c_power_off: cover property ($fell(main_pwr_o));
   c_blink: cover property (link_act_i && $fell(led_green_o));
endmodule
`default_nettype wire

/* File: test/sw_wake_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sw_wake_model
(
   // Clock
   input wire logic clk_i,
   // Switch and wake pins
   output logic pwr_sw_o,
   output pwr_pkg::wake_t wake_o
);
   initial
   begin
      pwr_sw_o = 1'b0;
      wake_o = '0;
   end
   // Press length in cycles must exceed the debounce to be seen
   task automatic press(input int n);
      @(posedge clk_i);
      pwr_sw_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      pwr_sw_o <= 1'b0;
   endtask
   // Held for eight cycles so the pin synchroniser catches it
   task automatic wake(input pwr_pkg::wake_t w);
      @(posedge clk_i);
      wake_o <= w;
      repeat (8) @(posedge clk_i);
      wake_o <= '0;
   endtask
endmodule
`default_nettype wire

/* File: test/power_state_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pwr_consts.svh"
module power_state_ctrl_tb;
   localparam int HOLD = 2000;
   logic clk_i, rst_i, cyc_i, stb_i, we_i;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i;
   logic link_up_i, link_act_i, link_100_i;
   logic [31:0] dat_o, rd;
   logic ack_o, pwr_sw_i, main_pwr_o, cpu_pwr_o, fan_en_o, cold_boot_o;
   logic led_green_o, led_yellow_o, irq_o, seen, seen0;
   pwr_pkg::wake_t wake_i;
   int error_cnt = 0;
   int checked = 0;
   power_state_ctrl #(.HOLD_CYC(HOLD), .BLINK_CYC(8)) u_power_state_ctrl
      (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .pwr_sw_i, .wake_i, .link_up_i, .link_act_i,
      .link_100_i, .main_pwr_o, .cpu_pwr_o, .fan_en_o, .cold_boot_o,
      .led_green_o, .led_yellow_o, .irq_o);
   sw_wake_model u_sw_wake_model
      (.clk_i, .pwr_sw_o(pwr_sw_i), .wake_o(wake_i));
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic close_out();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= s;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (ack_o !== 1'b1)
      begin
         error_cnt++;
         close_out();
      end
   endtask
   task automatic rdr(input logic [7:0] a);
      wb(1'b0, a, 32'h0, 4'hf);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hf);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   task automatic wait_st(input logic [31:0] e);
      int n;
      n = 0;
      do
      begin
         rdr(`OFF_STATE);
         n++;
      end
      while (rd !== e && n < 900);
      chk(rd, e);
      if (rd !== e)
         close_out();
   endtask
   task automatic ign(input pwr_pkg::wake_t w, input logic [31:0] e);
      u_sw_wake_model.wake(w);
      repeat (40) @(posedge clk_i);
      rdr(`OFF_STATE);
      chk(rd, e);
   endtask
   task automatic t_reset();
      rdr(`OFF_STATE);
      chk(rd, 32'h3);
      wb(1'b1, `OFF_CFG, 32'h3, 4'he);
      rdr(`OFF_CFG);
      chk(rd, 32'h0);
      rdr(8'h1c);
      chk(rd, 32'h0);
      chk({31'h0, main_pwr_o}, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_on();
      int n;
      u_sw_wake_model.press(1500);
      n = 0;
      while (cold_boot_o !== 1'b1 && n < 3000)
      begin
         @(posedge clk_i);
         n++;
      end
      chk({31'h0, cold_boot_o}, 32'h1);
      wait_st(32'h0);
      chk({30'h0, main_pwr_o, fan_en_o}, 32'h3);
      $display("power on test done");
   endtask
   task automatic t_sleep();
      wr(`OFF_IRQ_STAT, 32'h1f);
      wr(`OFF_IRQ_MASK, 32'h08);
      settle(0);
      chk({31'h0, irq_o}, 32'h0);
      u_sw_wake_model.press(1500);
      wait_st(32'h1);
      chk({30'h0, main_pwr_o, fan_en_o}, 32'h3);
      rdr(`OFF_IRQ_STAT);
      chk(rd & 32'h0a, 32'h0a);
      settle(0);
      chk({31'h0, irq_o}, 32'h1);
      wr(`OFF_IRQ_STAT, 32'h08);
      settle(0);
      chk({31'h0, irq_o}, 32'h0);
      $display("sleep test done");
   endtask
   task automatic t_s1();
      u_sw_wake_model.wake(6'h08);
      wait_st(32'h0);
      ign(6'h01, 32'h0);
      wr(`OFF_CMD, {29'h0, `CMD_SLEEP_S1});
      ign('0, 32'h1);
      u_sw_wake_model.wake(6'h02);
      wait_st(32'h0);
      wr(`OFF_CMD, {29'h0, `CMD_SLEEP_S1});
      wait_st(32'h1);
      u_sw_wake_model.press(1500);
      wait_st(32'h0);
      $display("sleep one test done");
   endtask
   task automatic t_s4();
      wr(`OFF_CMD, {29'h0, `CMD_SLEEP_S4});
      wait_st(32'h2);
      chk({30'h0, main_pwr_o, fan_en_o}, 32'h0);
      ign(6'h08, 32'h2);
      ign(6'h04, 32'h2);
      ign(6'h02, 32'h2);
      seen = 1'b0;
      fork
         u_sw_wake_model.wake(6'h20);
         repeat (60)
         begin
            @(posedge clk_i);
            seen = seen | cold_boot_o;
         end
      join
      chk({31'h0, seen}, 32'h0);
      wait_st(32'h0);
      $display("disk sleep test done");
   endtask
   task automatic t_s5();
      wr(`OFF_CMD, {29'h0, `CMD_SOFT_OFF});
      wait_st(32'h3);
      chk({31'h0, main_pwr_o}, 32'h0);
      ign(6'h20, 32'h3);
      ign(6'h10, 32'h3);
      u_sw_wake_model.wake(6'h01);
      wait_st(32'h0);
      u_sw_wake_model.press(HOLD + 1500);
      repeat (1400) @(posedge clk_i);
      wait_st(32'h3);
      wr(`OFF_CFG, 32'h1);
      u_sw_wake_model.wake(6'h20);
      wait_st(32'h0);
      $display("soft off test done");
   endtask
   task automatic t_leds();
      settle(6);
      chk({30'h0, led_green_o, led_yellow_o}, 32'h0);
      @(posedge clk_i);
      link_up_i <= 1'b1;
      link_100_i <= 1'b1;
      settle(6);
      chk({30'h0, led_green_o, led_yellow_o}, 32'h3);
      @(posedge clk_i);
      link_act_i <= 1'b1;
      seen = 1'b0;
      seen0 = 1'b0;
      repeat (40)
      begin
         settle(1);
         seen = seen | led_green_o;
         seen0 = seen0 | !led_green_o;
      end
      chk({30'h0, seen, seen0}, 32'h3);
      rdr(`OFF_LINK);
      chk(rd, 32'h7);
      $display("indicator test done");
   endtask
   initial
   begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'h0;
      dat_i = 32'h0;
      link_up_i = 1'b0;
      link_act_i = 1'b0;
      link_100_i = 1'b0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_on();
      t_sleep();
      t_s1();
      t_s4();
      t_s5();
      t_leds();
      close_out();
   end
endmodule
bind power_state_ctrl pwr_checker u_pwr_checker
   (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .link_up_i, .link_act_i,
   .link_100_i, .main_pwr_o, .cpu_pwr_o, .fan_en_o, .cold_boot_o,
   .led_green_o, .led_yellow_o);
`default_nettype wire
